// file: hw/fpbe_emitter.sv
`timescale 1ns/1ns
`default_nettype none
module fpbe_emitter #(
    parameter int unsigned MS_CYCLES = fpbe_pkg::MS_CYCLES_DEF
) (
    input  wire logic                             clk_in,
    input  wire logic                             nrst_in,
    input  wire logic signed [fpbe_pkg::FLOW_W-1:0] flow_ml_in,
    input  wire logic                             flow_valid_in,
    input  wire logic [2:0]                       size_sel_in,
    output logic                                  pulse_out,
    output logic [fpbe_pkg::CNT_W-1:0]            period_count_out,
    output logic                                  period_start_out
);
    import fpbe_pkg::*;

    fpbe_mem_if mem_bus ();

    fpbe_avg_mem u_mem (
        .clk_in (clk_in),
        .port   (mem_bus)
    );

    // Timebase: 1 ms enable and one-second boundary
    logic [DIV_W-1:0]  div_r;
    logic [9:0]        ms_r;
    logic              ms_tick;
    logic              sec_tick;

    assign ms_tick  = (div_r == DIV_W'(MS_CYCLES - 1));
    assign sec_tick = ms_tick && (ms_r == 10'(PERIOD_MS - 1));

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_r <= '0;
            ms_r  <= '0;
        end else begin
            div_r <= ms_tick ? '0 : div_r + 1'b1;
            if (ms_tick) begin
                ms_r <= sec_tick ? '0 : ms_r + 1'b1;
            end
        end
    end

    // Latest flow sample
    logic signed [FLOW_W-1:0] flow_r;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flow_r <= '0;
        end else if (flow_valid_in) begin
            flow_r <= flow_ml_in;
        end
    end

    // Meter factor by sensor size
    logic [8:0] factor;

    assign factor = (size_sel_in == SIZE_0P6) ? FACT_0P6 :
                    (size_sel_in == SIZE_1P5) ? FACT_1P5 :
                    (size_sel_in == SIZE_2P5) ? FACT_2P5 :
                    (size_sel_in == SIZE_3P5) ? FACT_3P5 :
                    (size_sel_in == SIZE_6)   ? FACT_6   : FACT_10;

    // Per-second calculation
    fpbe_calc_e               calc_r, calc_nxt;
    logic [PTR_W-1:0]         ptr_r, ptr_nxt;
    logic [AVG_DEPTH-1:0]     filled_r, filled_nxt;
    logic signed [SUM_W-1:0]  sum_r, sum_nxt;
    logic [ACC_W-1:0]         acc_r, acc_nxt;
    logic [ACC_W-1:0]         frac_r, frac_nxt;
    logic [CNT_W-1:0]         cnt_r, cnt_nxt;
    logic signed [FLOW_W-1:0] oldest;
    logic signed [SUM_W-1:0]  avg_full;
    logic signed [FLOW_W-1:0] avg;
    logic                     no_flow;
    logic [ACC_W-1:0]         total;
    logic                     saturate;
    logic                     div_more;
    logic                     load;

    assign oldest   = filled_r[ptr_r] ? mem_bus.rdata : '0;
    assign avg_full = sum_r >>> AVG_SHIFT;
    assign avg      = avg_full[FLOW_W-1:0];
    assign no_flow  = (avg < FLOW_W'(MIN_CUTOFF_ML));
    assign total    = frac_r + ACC_W'(avg[FLOW_W-2:0]) * ACC_W'(factor);
    assign saturate = (total >= ACC_W'(MAX_PULSES * ML_PER_L));
    assign div_more = (acc_r >= ACC_W'(ML_PER_L));
    assign load     = (calc_r == CALC_DONE);

    assign mem_bus.addr  = ptr_r;
    assign mem_bus.wdata = flow_r;
    assign mem_bus.we    = (calc_r == CALC_SUM);

    always_comb begin
        calc_nxt   = calc_r;
        ptr_nxt    = ptr_r;
        filled_nxt = filled_r;
        sum_nxt    = sum_r;
        acc_nxt    = acc_r;
        frac_nxt   = frac_r;
        cnt_nxt    = cnt_r;
        case (calc_r)
            CALC_IDLE: begin
                if (sec_tick) begin
                    calc_nxt = CALC_READ;
                end
            end
            CALC_READ: begin
                calc_nxt = CALC_SUM;
            end
            CALC_SUM: begin
                // Sliding window: drop oldest second, add newest
                sum_nxt = sum_r + SUM_W'(flow_r) - SUM_W'(oldest);
                filled_nxt[ptr_r] = 1'b1;
                ptr_nxt  = ptr_r + 1'b1;
                calc_nxt = CALC_SCALE;
            end
            CALC_SCALE: begin
                cnt_nxt = '0;
                if (no_flow) begin
                    frac_nxt = '0;
                    calc_nxt = CALC_DONE;
                end else if (saturate) begin
                    cnt_nxt  = CNT_W'(MAX_PULSES);
                    frac_nxt = '0;
                    calc_nxt = CALC_DONE;
                end else begin
                    acc_nxt  = total;
                    calc_nxt = CALC_DIV;
                end
            end
            CALC_DIV: begin
                if (div_more) begin
                    acc_nxt = acc_r - ACC_W'(ML_PER_L);
                    cnt_nxt = cnt_r + 1'b1;
                end else begin
                    frac_nxt = acc_r;
                    calc_nxt = CALC_DONE;
                end
            end
            CALC_DONE: begin
                calc_nxt = CALC_IDLE;
            end
            default: begin
                calc_nxt = CALC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            calc_r   <= CALC_IDLE;
            ptr_r    <= '0;
            filled_r <= '0;
            sum_r    <= '0;
            acc_r    <= '0;
            frac_r   <= '0;
            cnt_r    <= '0;
        end else begin
            calc_r   <= calc_nxt;
            ptr_r    <= ptr_nxt;
            filled_r <= filled_nxt;
            sum_r    <= sum_nxt;
            acc_r    <= acc_nxt;
            frac_r   <= frac_nxt;
            cnt_r    <= cnt_nxt;
        end
    end

    // Burst emission
    fpbe_em_e          em_r, em_nxt;
    logic [CNT_W-1:0]  left_r, left_nxt;
    logic [3:0]        burst_r, burst_nxt;
    logic [TMR_W-1:0]  tmr_r, tmr_nxt;
    logic              pulse_r, pulse_nxt;
    logic              tmr_done;
    logic              last_pulse;
    logic              burst_end;

    assign tmr_done   = ms_tick && (tmr_r == '0);
    assign last_pulse = (left_r == CNT_W'(1));
    assign burst_end  = (burst_r == 4'(BURST_PULSES - 1));

    always_comb begin
        em_nxt    = em_r;
        left_nxt  = left_r;
        burst_nxt = burst_r;
        tmr_nxt   = (ms_tick && tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
        if (load) begin
            // New period replaces whatever is left of the old one
            left_nxt  = cnt_r;
            burst_nxt = '0;
            tmr_nxt   = TMR_W'(PULSE_MS - 1);
            em_nxt    = (cnt_r != '0) ? EM_HIGH : EM_IDLE;
        end else begin
            case (em_r)
                EM_IDLE: begin
                end
                EM_HIGH: begin
                    if (tmr_done) begin
                        left_nxt  = left_r - 1'b1;
                        burst_nxt = burst_end ? '0 : burst_r + 1'b1;
                        if (last_pulse) begin
                            em_nxt = EM_IDLE;
                        end else if (burst_end) begin
                            tmr_nxt = TMR_W'(PAUSE_MS - 1);
                            em_nxt  = EM_PAUSE;
                        end else begin
                            tmr_nxt = TMR_W'(GAP_MS - 1);
                            em_nxt  = EM_LOW;
                        end
                    end
                end
                EM_LOW, EM_PAUSE: begin
                    if (tmr_done) begin
                        tmr_nxt = TMR_W'(PULSE_MS - 1);
                        em_nxt  = EM_HIGH;
                    end
                end
                default: begin
                    em_nxt = EM_IDLE;
                end
            endcase
        end
        pulse_nxt = (em_nxt == EM_HIGH);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            em_r    <= EM_IDLE;
            left_r  <= '0;
            burst_r <= '0;
            tmr_r   <= '0;
            pulse_r <= 1'b0;
        end else begin
            em_r    <= em_nxt;
            left_r  <= left_nxt;
            burst_r <= burst_nxt;
            tmr_r   <= tmr_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // Period report
    logic [CNT_W-1:0] period_cnt_r;
    logic             period_start_r;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            period_cnt_r   <= '0;
            period_start_r <= 1'b0;
        end else begin
            period_start_r <= load;
            if (load) begin
                period_cnt_r <= cnt_r;
            end
        end
    end

    assign pulse_out        = pulse_r;
    assign period_count_out = period_cnt_r;
    assign period_start_out = period_start_r;
endmodule
`default_nettype wire

// file: hw/fpbe_pkg.sv
// Operation
// - Recompute pulse count every second, restart period
// - Pulses sent in bursts, each 2-3 ms
// - About 30 ms pause between bursts
// - Count derived from averaged flow series
// - Pulse tail up to eight seconds after stop
// - Size-selected meter factor, rate saturates 125 Hz
// - No pulses below cut-off or reverse flow
// - Above saturation flow, hold maximum rate
// - Pulse count linear with flow in range
package fpbe_pkg;
    localparam int CLK_HZ        = 50_000_000;
    localparam int MS_PER_S      = 1000;
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int DIV_W         = 16;

    localparam int PERIOD_MS     = 1000;
    localparam int PULSE_MS      = 3;
    localparam int GAP_MS        = 2;
    localparam int PAUSE_MS      = 30;
    localparam int TMR_W         = 5;
    localparam int BURST_PULSES  = 16;
    localparam int MAX_PULSES    = 125;
    localparam int CNT_W         = 7;

    localparam int FLOW_W        = 16;
    localparam int AVG_DEPTH     = 8;
    localparam int AVG_SHIFT     = 3;
    localparam int PTR_W         = 3;
    localparam int SUM_W         = FLOW_W + AVG_SHIFT;
    localparam int ML_PER_L      = 1000;
    localparam int MIN_CUTOFF_ML = 2;
    localparam int ACC_W         = 26;

    localparam logic [2:0] SIZE_0P6 = 3'h0;
    localparam logic [2:0] SIZE_1P5 = 3'h1;
    localparam logic [2:0] SIZE_2P5 = 3'h2;
    localparam logic [2:0] SIZE_3P5 = 3'h3;
    localparam logic [2:0] SIZE_6   = 3'h4;
    localparam logic [8:0] FACT_0P6 = 9'h12c;
    localparam logic [8:0] FACT_1P5 = 9'h064;
    localparam logic [8:0] FACT_2P5 = 9'h03c;
    localparam logic [8:0] FACT_3P5 = 9'h032;
    localparam logic [8:0] FACT_6   = 9'h019;
    localparam logic [8:0] FACT_10  = 9'h00f;

    typedef enum logic [2:0] {
        CALC_IDLE  = 3'h0,
        CALC_READ  = 3'h1,
        CALC_SUM   = 3'h2,
        CALC_SCALE = 3'h3,
        CALC_DIV   = 3'h4,
        CALC_DONE  = 3'h5
    } fpbe_calc_e;

    typedef enum logic [1:0] {
        EM_IDLE  = 2'h0,
        EM_HIGH  = 2'h1,
        EM_LOW   = 2'h2,
        EM_PAUSE = 2'h3
    } fpbe_em_e;
endpackage

// file: hw/fpbe_mem_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fpbe_mem_if;
    import fpbe_pkg::*;
    logic                     we;
    logic [PTR_W-1:0]         addr;
    logic signed [FLOW_W-1:0] wdata;
    logic signed [FLOW_W-1:0] rdata;
    modport user (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: hw/fpbe_avg_mem.sv
`timescale 1ns/1ns
`default_nettype none
module fpbe_avg_mem (
    input wire logic   clk_in,
    fpbe_mem_if.mem    port
);
    import fpbe_pkg::*;

    logic signed [FLOW_W-1:0] ram [AVG_DEPTH];
    logic signed [FLOW_W-1:0] rdata_r;

    // Read-before-write: the slot being replaced reads out its old sample
    always_ff @(posedge clk_in) begin
        if (port.we) begin
            ram[port.addr] <= port.wdata;
        end
        rdata_r <= ram[port.addr];
    end

    assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// file: verif/fpbe_emitter_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module fpbe_emitter_asserts #(
    parameter int unsigned MS_CYCLES = 10
) (
    input wire logic                                clk_in,
    input wire logic                                nrst_in,
    input wire logic signed [fpbe_pkg::FLOW_W-1:0] flow_ml_in,
    input wire logic                                flow_valid_in,
    input wire logic [2:0]                          size_sel_in,
    input wire logic                                pulse_out,
    input wire logic [fpbe_pkg::CNT_W-1:0]          period_count_out,
    input wire logic                                period_start_out
);
    import fpbe_pkg::*;
    localparam int MS      = int'(MS_CYCLES);
    localparam int SPAN_LO = 1000 * MS - 140;
    localparam int SPAN_HI = 1000 * MS + 140;
    logic [31:0] hi_r;
    logic [31:0] lo_r;
    logic [31:0] gap_r;
    logic [7:0]  np_r;
    logic        rise_w;
    logic        after_burst_w;
    assign rise_w        = pulse_out && (lo_r != 0);
    assign after_burst_w = (np_r[3:0] == 4'h1) && (np_r > 8'h01);

    // Pulse widths, low spans, pulses and cycles within the period
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hi_r  <= '0;
            lo_r  <= '0;
            gap_r <= '0;
            np_r  <= '0;
        end else begin
            hi_r  <= pulse_out ? hi_r + 1 : '0;
            lo_r  <= pulse_out ? '0 : lo_r + 1;
            gap_r <= period_start_out ? 32'h1 : gap_r + 1;
            np_r  <= period_start_out ? {7'h00, pulse_out} : np_r + {7'h00, rise_w};
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_start_single: assert property (period_start_out |=> !period_start_out)
        else $error("period start longer than one cycle");
    a_count_update: assert property ($changed(period_count_out) |-> period_start_out)
        else $error("count changed outside a period load");
    a_start_spacing: assert property (period_start_out |-> gap_r >= SPAN_LO && gap_r <= SPAN_HI)
        else $error("period starts not one second apart");
    a_first_pulse: assert property (period_start_out && period_count_out != '0 |-> pulse_out)
        else $error("no pulse at period load");
    a_zero_quiet: assert property (period_count_out == '0 |-> !pulse_out)
        else $error("pulse in an empty period");
    a_count_ceiling: assert property (period_count_out <= CNT_W'(MAX_PULSES))
        else $error("period count above saturation");
    a_width_range: assert property ($fell(pulse_out) |-> hi_r >= 2 * MS - 1 && hi_r <= 3 * MS + 1)
        else $error("pulse width out of range");
    // First pulse of a period rises with the start strobe and is not spaced
    a_gap_length: assert property ((!pulse_out ##1 (pulse_out && !period_start_out)
        ##1 !period_start_out) |->
        (after_burst_w ? ($past(lo_r) + 2 >= 30 * MS && $past(lo_r) <= 30 * MS + 2)
                       : ($past(lo_r) + 2 >= 2 * MS && $past(lo_r) <= 2 * MS + 2)))
        else $error("pulse spacing wrong");
    a_pulses_in_count: assert property ($stable(period_count_out) && !period_start_out
        |-> np_r <= {1'b0, period_count_out})
        else $error("more pulses than scheduled");

    cover property (period_start_out && period_count_out == CNT_W'(MAX_PULSES));
    cover property (period_start_out && period_count_out == '0);
    cover property ((!pulse_out ##1 pulse_out ##1 !period_start_out) and after_burst_w);
endmodule
`default_nettype wire

// file: verif/fpbe_meter_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpbe_meter_model (
    input wire logic  clk_in,
    input wire logic  nrst_in,
    input wire logic  pulse_in,
    input wire logic  clear_in,
    output logic [7:0] tally_out
);
    logic prev_r;
    // Counts rising edges like the calculator's pulse input
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_r    <= 1'b0;
            tally_out <= 8'h00;
        end else begin
            prev_r <= pulse_in;
            // A clear keeps an edge seen in the same cycle
            if (clear_in) tally_out <= {7'h00, pulse_in && !prev_r};
            else if (pulse_in && !prev_r) tally_out <= tally_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: verif/flow_pulse_burst_emitter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module flow_pulse_burst_emitter_tb_top;
    import fpbe_pkg::*;
    localparam int unsigned MS = 4;
    localparam int          SEC = 1000 * MS;
    logic                     clk_in, nrst_in, flow_valid_in, clr;
    logic signed [FLOW_W-1:0] flow_ml_in;
    logic [2:0]               size_sel_in;
    logic                     pulse_out, period_start_out;
    logic [CNT_W-1:0]         period_count_out;
    logic [7:0]               tally;
    int err_count, samples_checked, cur, frac, prev;
    int win[8];

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    fpbe_emitter #(.MS_CYCLES(MS)) fpbe_emitter_i (.clk_in, .nrst_in, .flow_ml_in,
        .flow_valid_in, .size_sel_in, .pulse_out, .period_count_out, .period_start_out);
    fpbe_meter_model fpbe_meter_model_i (.clk_in, .nrst_in, .pulse_in(pulse_out),
        .clear_in(clr), .tally_out(tally));

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("Checked %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    function automatic int factor(logic [2:0] s);
        case (s)
            3'h0: return 300;
            3'h1: return 100;
            3'h2: return 60;
            3'h3: return 50;
            3'h4: return 25;
            default: return 15;
        endcase
    endfunction

    task automatic set_flow(int f, logic [2:0] s);
        @(negedge clk_in);
        cur = f;
        flow_ml_in = FLOW_W'(f);
        size_sel_in = s;
        flow_valid_in = 1'b1;
        @(negedge clk_in);
        flow_valid_in = 1'b0;
    endtask

    // Waits for n period loads, predicting each from a window of samples
    task automatic step(int n);
        int k, sum, avg, acc, c;
        for (int i = 0; i < n; i++) begin
            k = 0;
            while (period_start_out !== 1'b1 && k < SEC + 400) begin
                @(negedge clk_in);
                k++;
            end
            check("period_start_out", 1, period_start_out);
            for (int j = 7; j > 0; j--) win[j] = win[j-1];
            win[0] = cur;
            sum = 0;
            foreach (win[j]) sum += win[j];
            avg = sum >>> 3;
            acc = frac + avg * factor(size_sel_in);
            if (avg < 2) begin
                c = 0;
                frac = 0;
            end else if (acc >= 125000) begin
                c = 125;
                frac = 0;
            end else begin
                c = acc / 1000;
                frac = acc % 1000;
            end
            check("period_count_out", c, period_count_out);
            check("tally", prev, tally);
            prev = c;
            clr = 1'b1;
            @(negedge clk_in);
            clr = 1'b0;
        end
    endtask

    task automatic t_reset;
        check("pulse_out", 0, pulse_out);
        check("period_count_out", 0, period_count_out);
        $display("t_reset done");
    endtask

    task automatic t_linear;
        set_flow(250, 3'h1);
        step(4);
        $display("t_linear done");
    endtask

    task automatic t_factors;
        for (int s = 0; s < 6; s++) begin
            set_flow(40, 3'(s));
            step(1);
        end
        $display("t_factors done");
    endtask

    task automatic t_saturate;
        set_flow(20000, 3'h0);
        step(3);
        $display("t_saturate done");
    endtask

    task automatic t_reverse;
        set_flow(-500, 3'h2);
        step(8);
        check("pulse_out", 0, pulse_out);
        $display("t_reverse done");
    endtask

    initial begin
        {nrst_in, flow_valid_in, clr, size_sel_in, flow_ml_in} = '0;
        {err_count, samples_checked, cur, frac, prev} = '0;
        foreach (win[j]) win[j] = 0;
        repeat (8) @(negedge clk_in);
        t_reset();
        nrst_in = 1'b1;
        t_linear();
        t_factors();
        t_saturate();
        t_reverse();
        report_and_stop();
    end

    initial begin
        repeat (SEC * 23) @(posedge clk_in);
        err_count++;
        $display("MISMATCH watchdog expected 0 seen 1");
        report_and_stop();
    end
endmodule

bind fpbe_emitter fpbe_emitter_asserts #(.MS_CYCLES(MS_CYCLES)) fpbe_emitter_asserts_i (
    .clk_in, .nrst_in, .flow_ml_in, .flow_valid_in, .size_sel_in, .pulse_out,
    .period_count_out, .period_start_out);
`default_nettype wire
